// [gcr_regbank.sv]
// Channel global configuration register bank with serial-port address pointer
`timescale 1ns/1ps
module gcr_regbank #(
    parameter int unsigned ADDR_W = gcr_pkg::ADDR_WIDTH
) (
    input  wire logic              core_clk_in,
    input  wire logic              srst_in,
    input  wire logic              hw_rst_n_in,
    input  wire logic [2:0]        strap_mclk_in,
    input  wire logic              host_addr_load_in,
    input  wire logic [ADDR_W-1:0] host_addr_in,
    input  wire logic              host_wr_in,
    input  wire logic              host_rd_in,
    input  wire logic [7:0]        host_wdata_in,
    output logic      [7:0]        host_rdata_out,
    output logic                   host_rdata_valid_out,
    output logic                   ee_sel_out,
    output logic                   ee_wr_out,
    output logic                   ee_rd_out,
    output logic      [ADDR_W-1:0] ee_addr_out,
    output logic      [7:0]        ee_wdata_out,
    input  wire logic [7:0]        ee_rdata_in,
    input  wire logic              nco_only_in,
    input  wire logic              ext_sw_en_in,
    input  wire logic [1:0]        gpio23_level_in,
    input  wire logic              pin0_status_in,
    input  wire logic              pin1_status_in,
    input  wire logic              gpio0_pin_in,
    output logic                   gpio0_pin_out,
    output logic                   gpio0_pin_oe_out,
    input  wire logic              gpio1_pin_in,
    output logic                   gpio1_pin_out,
    output logic                   gpio1_pin_oe_out,
    output logic      [1:0]        pin_level_status_out,
    output logic                   channel_reset_out,
    output logic      [1:0]        mclk_src_out,
    output logic                   ring_osc_pd_out,
    output logic                   xa_enable_out,
    output logic      [1:0]        mclk_range_out,
    output logic                   mclk_range_used_out,
    output logic                   dpll_en_out,
    output logic                   apll_en_out,
    output logic      [2:0]        ic_en_out,
    output logic      [2:0]        oc_en_out,
    output logic                   ext_switch_out
);
    // ****************************************
    // Hardware reset pin and strap capture
    // ****************************************
    logic       hwr_meta_q;
    logic       hwr_sync_q;
    logic [2:0] strap_meta_q;
    logic [2:0] strap_sync_q;
    logic [2:0] strap_d;
    logic [2:0] strap_q;
    logic       hard_rst;

    assign hard_rst = srst_in | ~hwr_sync_q;

    always_comb begin
        strap_d = strap_q;
        if (!hwr_sync_q) begin
            strap_d = strap_sync_q;
        end
    end

    // Reset pin reads as asserted during srst_in, so straps are captured then too
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            hwr_meta_q <= 1'b0;
            hwr_sync_q <= 1'b0;
        end else begin
            hwr_meta_q <= hw_rst_n_in;
            hwr_sync_q <= hwr_meta_q;
        end
    end

    always_ff @(posedge core_clk_in) begin
        strap_meta_q <= strap_mclk_in;
        strap_sync_q <= strap_meta_q;
        strap_q      <= strap_d;
    end

    // ****************************************
    // Register file and address pointer
    // ****************************************
    logic              bank_d, bank_q;
    logic [7:0]        mcfg1_d, mcfg1_q;
    logic [7:0]        mcfg2_d, mcfg2_q;
    logic [7:0]        pll_enables_d, pll_enables_q;
    logic [7:0]        input_clock_enables_d, input_clock_enables_q;
    logic [7:0]        output_clock_enables_d, output_clock_enables_q;
    logic [7:0]        pincfg_d, pincfg_q;
    logic [ADDR_W-1:0] ptr_d, ptr_q;
    logic              xfer_wr;
    logic              xfer_rd;
    logic              ee_hit;
    logic              soft_d;

    assign xfer_wr = host_wr_in & ~host_addr_load_in;
    assign xfer_rd = host_rd_in & ~host_wr_in & ~host_addr_load_in;
    assign ee_hit  = bank_q & (ptr_q != gcr_pkg::ADDR_BANK);

    always_comb begin
        bank_d   = bank_q;
        mcfg1_d  = mcfg1_q;
        mcfg2_d  = mcfg2_q;
        pll_enables_d  = pll_enables_q;
        input_clock_enables_d   = input_clock_enables_q;
        output_clock_enables_d   = output_clock_enables_q;
        pincfg_d = pincfg_q;
        ptr_d    = ptr_q;
        if (xfer_wr && (ptr_q == gcr_pkg::ADDR_BANK)) begin
            bank_d = host_wdata_in[0];
        end else if (xfer_wr && !ee_hit) begin
            // Writes to unused addresses are dropped; reserved bits are masked to zero
            unique case (ptr_q)
                gcr_pkg::ADDR_MCFG1:  mcfg1_d  = host_wdata_in & gcr_pkg::MASK_MCFG1;
                gcr_pkg::ADDR_MCFG2:  mcfg2_d  = host_wdata_in & gcr_pkg::MASK_MCFG2;
                gcr_pkg::ADDR_PLL_ENABLES:  pll_enables_d  = host_wdata_in & gcr_pkg::MASK_PLL_ENABLES;
                gcr_pkg::ADDR_INPUT_CLOCK_ENABLES:   input_clock_enables_d   = host_wdata_in & gcr_pkg::MASK_CLKEN;
                gcr_pkg::ADDR_OUTPUT_CLOCK_ENABLES:   output_clock_enables_d   = host_wdata_in & gcr_pkg::MASK_CLKEN;
                gcr_pkg::ADDR_PINCFG: pincfg_d = host_wdata_in & gcr_pkg::MASK_PINCFG;
                default:              pincfg_d = pincfg_q;
            endcase
        end
        soft_d = mcfg1_d[gcr_pkg::BIT_SOFT_RST];
        if (soft_d) begin
            // Every register but the reset bit is held at its default; the address pointer still loads and advances
            bank_d   = 1'b0;
            mcfg1_d  = gcr_pkg::RST_VAL;
            mcfg1_d[gcr_pkg::BIT_SOFT_RST] = 1'b1;
            mcfg2_d  = {gcr_pkg::RST_VAL[7:3], strap_q};
            pll_enables_d  = gcr_pkg::RST_VAL;
            input_clock_enables_d   = gcr_pkg::RST_VAL;
            output_clock_enables_d   = gcr_pkg::RST_VAL;
            pincfg_d = gcr_pkg::RST_VAL;
        end
        if (host_addr_load_in) begin
            ptr_d = host_addr_in;
        end else if ((xfer_wr || xfer_rd) && !mcfg2_q[gcr_pkg::BIT_AINC_DIS]) begin
            ptr_d = ptr_q + gcr_pkg::ADDR_STEP;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (hard_rst) begin
            bank_q   <= 1'b0;
            mcfg1_q  <= gcr_pkg::RST_VAL;
            mcfg2_q  <= {gcr_pkg::RST_VAL[7:3], strap_d};
            pll_enables_q  <= gcr_pkg::RST_VAL;
            input_clock_enables_q   <= gcr_pkg::RST_VAL;
            output_clock_enables_q   <= gcr_pkg::RST_VAL;
            pincfg_q <= gcr_pkg::RST_VAL;
            ptr_q    <= gcr_pkg::ADDR_BANK;
        end else begin
            bank_q   <= bank_d;
            mcfg1_q  <= mcfg1_d;
            mcfg2_q  <= mcfg2_d;
            pll_enables_q  <= pll_enables_d;
            input_clock_enables_q   <= input_clock_enables_d;
            output_clock_enables_q   <= output_clock_enables_d;
            pincfg_q <= pincfg_d;
            ptr_q    <= ptr_d;
        end
    end

    // ****************************************
    // Read path and EEPROM window
    // ****************************************
    logic              rd_pend_d, rd_pend_q;
    logic              rd_ee_d, rd_ee_q;
    logic [ADDR_W-1:0] rd_addr_d, rd_addr_q;
    logic [7:0]        rdata_d, rdata_q;
    logic              rvalid_d, rvalid_q;
    logic              ee_wr_d, ee_wr_q;
    logic              ee_rd_d, ee_rd_q;
    logic [ADDR_W-1:0] ee_addr_d, ee_addr_q;
    logic [7:0]        ee_wdata_d, ee_wdata_q;

    always_comb begin
        rd_pend_d  = xfer_rd;
        rd_ee_d    = xfer_rd & ee_hit;
        rd_addr_d  = ptr_q;
        ee_wr_d    = xfer_wr & ee_hit;
        ee_rd_d    = xfer_rd & ee_hit;
        ee_addr_d  = (xfer_wr || xfer_rd) ? ptr_q : ee_addr_q;
        ee_wdata_d = xfer_wr ? host_wdata_in : ee_wdata_q;
        rvalid_d   = rd_pend_q;
        rdata_d    = rdata_q;
        if (rd_pend_q && rd_ee_q) begin
            rdata_d = ee_rdata_in;
        end else if (rd_pend_q) begin
            unique case (rd_addr_q)
                gcr_pkg::ADDR_MCFG1:  rdata_d = mcfg1_q;
                gcr_pkg::ADDR_MCFG2:  rdata_d = mcfg2_q;
                gcr_pkg::ADDR_PLL_ENABLES:  rdata_d = pll_enables_q;
                gcr_pkg::ADDR_INPUT_CLOCK_ENABLES:   rdata_d = input_clock_enables_q;
                gcr_pkg::ADDR_OUTPUT_CLOCK_ENABLES:   rdata_d = output_clock_enables_q;
                gcr_pkg::ADDR_PINCFG: rdata_d = pincfg_q;
                default:              rdata_d = gcr_pkg::RST_VAL;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (hard_rst) begin
            rd_pend_q  <= 1'b0;
            rd_ee_q    <= 1'b0;
            rd_addr_q  <= gcr_pkg::ADDR_BANK;
            rdata_q    <= gcr_pkg::RST_VAL;
            rvalid_q   <= 1'b0;
            ee_wr_q    <= 1'b0;
            ee_rd_q    <= 1'b0;
            ee_addr_q  <= gcr_pkg::ADDR_BANK;
            ee_wdata_q <= gcr_pkg::RST_VAL;
        end else begin
            rd_pend_q  <= rd_pend_d;
            rd_ee_q    <= rd_ee_d;
            rd_addr_q  <= rd_addr_d;
            rdata_q    <= rdata_d;
            rvalid_q   <= rvalid_d;
            ee_wr_q    <= ee_wr_d;
            ee_rd_q    <= ee_rd_d;
            ee_addr_q  <= ee_addr_d;
            ee_wdata_q <= ee_wdata_d;
        end
    end

    // ****************************************
    // General-purpose pins
    // ****************************************
    gcr_pin_if pin0_if ();
    gcr_pin_if pin1_if ();

    assign pin0_if.mode       = pincfg_q[gcr_pkg::LSB_PIN0 +: 4];
    assign pin0_if.status_bit = pin0_status_in;
    assign pin1_if.mode       = pincfg_q[gcr_pkg::LSB_PIN1 +: 4];
    assign pin1_if.status_bit = pin1_status_in;

    gcr_gpio_pin u_pin0 (
        .core_clk_in (core_clk_in),
        .srst_in     (hard_rst),
        .pin_in      (gpio0_pin_in),
        .cfg         (pin0_if.pin)
    );

    gcr_gpio_pin u_pin1 (
        .core_clk_in (core_clk_in),
        .srst_in     (hard_rst),
        .pin_in      (gpio1_pin_in),
        .cfg         (pin1_if.pin)
    );

    // ****************************************
    // Channel control outputs
    // ****************************************
    gcr_pkg::gcr_ctl_t ctl_d, ctl_q;
    logic [3:0]        pin_levels;

    assign pin_levels = {gpio23_level_in, pin1_if.level, pin0_if.level};

    always_comb begin
        ctl_d          = ctl_q;
        ctl_d.soft_rst = mcfg1_q[gcr_pkg::BIT_SOFT_RST];
        if (mcfg1_q[gcr_pkg::BIT_SEL_IC1]) begin
            ctl_d.src = gcr_pkg::GCR_SRC_IC1;
        end else if (mcfg1_q[gcr_pkg::BIT_SEL_XA]) begin
            ctl_d.src = gcr_pkg::GCR_SRC_XA;
        end else begin
            ctl_d.src = gcr_pkg::GCR_SRC_RING;
        end
        ctl_d.ring_pd    = mcfg1_q[gcr_pkg::BIT_RING_PD];
        ctl_d.xa_en      = (mcfg1_q[1:0] == gcr_pkg::XAB_ON);
        ctl_d.range      = mcfg2_q[2:1];
        ctl_d.range_used = ~nco_only_in;
        ctl_d.dpll_en    = pll_enables_q[gcr_pkg::BIT_DPLL_EN];
        ctl_d.apll_en    = pll_enables_q[gcr_pkg::BIT_APLL_EN];
        ctl_d.ic_en      = input_clock_enables_q[2:0];
        ctl_d.oc_en      = output_clock_enables_q[2:0];
        ctl_d.ext_sw     = ext_sw_en_in & pin_levels[mcfg2_q[gcr_pkg::LSB_EXT_SRC +: 2]];
    end

    always_ff @(posedge core_clk_in) begin
        if (hard_rst) begin
            ctl_q <= '0;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign host_rdata_out       = rdata_q;
    assign host_rdata_valid_out = rvalid_q;
    assign ee_sel_out           = bank_q;
    assign ee_wr_out            = ee_wr_q;
    assign ee_rd_out            = ee_rd_q;
    assign ee_addr_out          = ee_addr_q;
    assign ee_wdata_out         = ee_wdata_q;
    assign gpio0_pin_out        = pin0_if.drive;
    assign gpio0_pin_oe_out     = pin0_if.oe;
    assign gpio1_pin_out        = pin1_if.drive;
    assign gpio1_pin_oe_out     = pin1_if.oe;
    assign pin_level_status_out = {pin1_if.level, pin0_if.level};
    assign channel_reset_out    = ctl_q.soft_rst;
    assign mclk_src_out         = ctl_q.src;
    assign ring_osc_pd_out      = ctl_q.ring_pd;
    assign xa_enable_out        = ctl_q.xa_en;
    assign mclk_range_out       = ctl_q.range;
    assign mclk_range_used_out  = ctl_q.range_used;
    assign dpll_en_out          = ctl_q.dpll_en;
    assign apll_en_out          = ctl_q.apll_en;
    assign ic_en_out            = ctl_q.ic_en;
    assign oc_en_out            = ctl_q.oc_en;
    assign ext_switch_out       = ctl_q.ext_sw;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (hard_rst);

    soft_clear_a: assert property (mcfg1_q[7] |->
        (pll_enables_q == 8'h00 && input_clock_enables_q == 8'h00 && output_clock_enables_q == 8'h00 && pincfg_q == 8'h00 && !bank_q))
        else $error("field left non-default during channel reset");
    strap_reload_a: assert property (mcfg1_q[7] |-> mcfg2_q[2:0] == strap_q)
        else $error("strapped field not reloaded during channel reset");
    auto_inc_a: assert property ((xfer_wr && !mcfg2_q[4]) |=>
        ptr_q == ADDR_W'($past(ptr_q) + 1'b1))
        else $error("address did not advance after a byte");
    addr_hold_a: assert property (((xfer_wr || xfer_rd) && mcfg2_q[4]) |=> $stable(ptr_q))
        else $error("address moved with auto-increment disabled");
    ic1_override_a: assert property (mcfg1_q[5] |=> mclk_src_out == 2'h2)
        else $error("input clock one does not override the clock select");
    xa_mode_a: assert property ((mcfg1_q[1:0] != 2'h2) |=> !xa_enable_out)
        else $error("oscillator pin enabled by a non-enabling code");
    ee_route_a: assert property ((xfer_rd && ee_hit) |=> ee_rd_out ##1 host_rdata_valid_out)
        else $error("EEPROM read not routed in two cycles");
    ee_write_a: assert property ((xfer_wr && ee_hit) |=> ee_wr_out)
        else $error("EEPROM write not routed");
    bank_read_a: assert property ((xfer_rd && ptr_q == 12'h000) |-> ##2
        (host_rdata_valid_out && host_rdata_out == 8'h00))
        else $error("bank select read back non-zero");
    clk_enable_a: assert property (ic_en_out == $past(input_clock_enables_q[2:0]) &&
        oc_en_out == $past(output_clock_enables_q[2:0]))
        else $error("clock enable outputs do not follow their registers");

    soft_reset_c: cover property (xfer_wr && ptr_q == 12'h009 && host_wdata_in[7]
        ##1 channel_reset_out [*2]);
    ee_read_c: cover property (bank_q && xfer_rd ##2 host_rdata_valid_out);
    fixed_addr_c: cover property (mcfg2_q[4] && xfer_wr ##1 xfer_wr);
endmodule : gcr_regbank

// [gcr_pkg.sv]
// Constants and types for the channel global configuration register bank
package gcr_pkg;
    localparam int unsigned ADDR_WIDTH  = 12;
    localparam logic [11:0] ADDR_BANK    = 12'h000;
    localparam logic [11:0] ADDR_MCFG1   = 12'h009;
    localparam logic [11:0] ADDR_MCFG2   = 12'h00a;
    localparam logic [11:0] ADDR_PLL_ENABLES   = 12'h00b;
    localparam logic [11:0] ADDR_INPUT_CLOCK_ENABLES    = 12'h00c;
    localparam logic [11:0] ADDR_OUTPUT_CLOCK_ENABLES    = 12'h00d;
    localparam logic [11:0] ADDR_PINCFG  = 12'h00e;
    localparam logic [11:0] ADDR_STEP    = 12'h001;

    localparam logic [7:0]  RST_VAL      = 8'h00;
    localparam logic [7:0]  MASK_MCFG1   = 8'hbf;
    localparam logic [7:0]  MASK_MCFG2   = 8'h77;
    localparam logic [7:0]  MASK_PLL_ENABLES   = 8'h11;
    localparam logic [7:0]  MASK_CLKEN   = 8'h07;
    localparam logic [7:0]  MASK_PINCFG  = 8'hff;

    localparam int unsigned BIT_SOFT_RST = 7;
    localparam int unsigned BIT_SEL_IC1  = 5;
    localparam int unsigned BIT_SEL_XA   = 4;
    localparam int unsigned BIT_RING_PD  = 3;
    localparam int unsigned BIT_AINC_DIS = 4;
    localparam int unsigned BIT_DPLL_EN  = 4;
    localparam int unsigned BIT_APLL_EN  = 0;
    localparam int unsigned LSB_EXT_SRC  = 5;
    localparam int unsigned LSB_PIN1     = 4;
    localparam int unsigned LSB_PIN0     = 0;

    localparam logic [1:0]  XAB_ON       = 2'h2;
    localparam logic [3:0]  PIN_IN       = 4'h0;
    localparam logic [3:0]  PIN_IN_INV   = 4'h1;
    localparam logic [3:0]  PIN_OUT_LO   = 4'h2;
    localparam logic [3:0]  PIN_OUT_HI   = 4'h3;
    localparam logic [3:0]  PIN_ST_TRUE  = 4'h4;
    localparam logic [3:0]  PIN_ST_INV   = 4'h5;
    localparam logic [3:0]  PIN_ST_OD1Z  = 4'h6;
    localparam logic [3:0]  PIN_ST_OD0Z  = 4'h7;

    typedef enum logic [1:0] {
        GCR_SRC_RING,
        GCR_SRC_XA,
        GCR_SRC_IC1
    } gcr_mclk_src_t;

    typedef struct packed {
        logic          soft_rst;
        gcr_mclk_src_t src;
        logic          ring_pd;
        logic          xa_en;
        logic [1:0]    range;
        logic          range_used;
        logic          dpll_en;
        logic          apll_en;
        logic [2:0]    ic_en;
        logic [2:0]    oc_en;
        logic          ext_sw;
    } gcr_ctl_t;
endpackage : gcr_pkg

// [gcr_pin_if.sv]
// Interface between the register bank and one general-purpose pin block
`timescale 1ns/1ps
interface gcr_pin_if;
    logic [3:0] mode;
    logic       status_bit;
    logic       level;
    logic       drive;
    logic       oe;

    modport bank (output mode, output status_bit, input level, input drive, input oe);
    modport pin  (input mode, input status_bit, output level, output drive, output oe);
endinterface : gcr_pin_if

// [gcr_gpio_pin.sv]
// One general-purpose pin: input sampling, driven output and status output
`timescale 1ns/1ps
module gcr_gpio_pin (
    input  wire logic core_clk_in,
    input  wire logic srst_in,
    input  wire logic pin_in,
    gcr_pin_if.pin    cfg
);
    logic meta_q;
    logic sync_q;
    logic level_d;
    logic level_q;
    logic drive_d;
    logic drive_q;
    logic oe_d;
    logic oe_q;

    // ****************************************
    // Pin function decode
    // ****************************************
    always_comb begin
        level_d = sync_q;
        drive_d = 1'b0;
        oe_d    = 1'b0;
        unique case (cfg.mode)
            gcr_pkg::PIN_IN_INV: begin
                level_d = ~sync_q;
            end
            gcr_pkg::PIN_OUT_LO: begin
                oe_d = 1'b1;
            end
            gcr_pkg::PIN_OUT_HI: begin
                drive_d = 1'b1;
                oe_d    = 1'b1;
            end
            gcr_pkg::PIN_ST_TRUE: begin
                drive_d = cfg.status_bit;
                oe_d    = 1'b1;
            end
            gcr_pkg::PIN_ST_INV: begin
                drive_d = ~cfg.status_bit;
                oe_d    = 1'b1;
            end
            gcr_pkg::PIN_ST_OD1Z: begin
                oe_d = ~cfg.status_bit;
            end
            gcr_pkg::PIN_ST_OD0Z: begin
                oe_d = cfg.status_bit;
            end
            default: begin
                // Plain input and unused codes leave the pin undriven
                oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            meta_q  <= 1'b0;
            sync_q  <= 1'b0;
            level_q <= 1'b0;
            drive_q <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            meta_q  <= pin_in;
            sync_q  <= meta_q;
            level_q <= level_d;
            drive_q <= drive_d;
            oe_q    <= oe_d;
        end
    end

    assign cfg.level = level_q;
    assign cfg.drive = drive_q;
    assign cfg.oe    = oe_q;

    // ****************************************
    // Checks
    // ****************************************
    drive_low_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        (cfg.mode == gcr_pkg::PIN_OUT_LO) |=> (oe_q && !drive_q))
        else $error("pin not driven low in drive-low mode");
    open_drain_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        (cfg.mode == gcr_pkg::PIN_ST_OD1Z && cfg.status_bit) |=> !oe_q)
        else $error("pin driven while status is one in open-drain mode");
    unused_safe_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        cfg.mode[3] |=> !oe_q)
        else $error("unused pin code drives the pin");
    status_out_c: cover property (@(posedge core_clk_in) disable iff (srst_in)
        cfg.mode == gcr_pkg::PIN_ST_INV ##1 oe_q);
endmodule : gcr_gpio_pin

// [gcr_regbank_tb.sv]
// Self-checking bench for the channel global configuration register bank
`timescale 1ns/1ps
module gcr_regbank_tb;
    logic        core_clk_in = 0, srst_in = 1, hw_rst_n_in = 0, host_addr_load_in = 0;
    logic        host_wr_in = 0, host_rd_in = 0, nco_only_in = 0, ext_sw_en_in = 0;
    logic        pin0_status_in = 0, pin1_status_in = 0, gpio0_pin_in = 0, gpio1_pin_in = 0;
    logic [2:0]  strap_mclk_in = 3'h5;
    logic [11:0] host_addr_in = 12'h000;
    logic [7:0]  host_wdata_in = 8'h00, ee_rdata_in = 8'ha5;
    logic [1:0]  gpio23_level_in = 2'h1;
    logic [7:0]  host_rdata_out, ee_wdata_out;
    logic [11:0] ee_addr_out;
    logic [1:0]  pin_level_status_out, mclk_src_out, mclk_range_out;
    logic [2:0]  ic_en_out, oc_en_out;
    logic        host_rdata_valid_out, ee_sel_out, ee_wr_out, ee_rd_out, gpio0_pin_out;
    logic        gpio0_pin_oe_out, gpio1_pin_out, gpio1_pin_oe_out, channel_reset_out;
    logic        ring_osc_pd_out, xa_enable_out, mclk_range_used_out, dpll_en_out;
    logic        apll_en_out, ext_switch_out;
    logic [7:0]  wv [6] = '{8'h7b, 8'h67, 8'hff, 8'hff, 8'hff, 8'h32};
    logic [7:0]  mk [6] = '{gcr_pkg::MASK_MCFG1, gcr_pkg::MASK_MCFG2, gcr_pkg::MASK_PLL_ENABLES,
                            gcr_pkg::MASK_CLKEN, gcr_pkg::MASK_CLKEN, gcr_pkg::MASK_PINCFG};
    int          num_errors = 0, n_tests = 0, cyc = 0;
    gcr_regbank u_gcr_regbank (.*);
    always #20 core_clk_in = ~core_clk_in;
    // ********************
    // Host access tasks
    // ********************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Bits of k are {read, write, load}
    task automatic go(input logic [2:0] k, input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        {host_rd_in, host_wr_in, host_addr_load_in} <= k;
        host_addr_in <= a;
        host_wdata_in <= d;
        @(posedge core_clk_in);
        {host_rd_in, host_wr_in, host_addr_load_in} <= 3'h0;
    endtask : go
    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        go(3'h1, a, 8'h00);
        go(3'h2, a, d);
        repeat (2) @(posedge core_clk_in);
        #1;
    endtask : wreg
    // Read answer stands between the first and second edges after the taking edge
    task automatic rd(input logic [7:0] e);
        go(3'h4, 12'h000, 8'h00);
        @(posedge core_clk_in);
        #1;
        chk({7'h00, host_rdata_valid_out}, 8'h01);
        chk(host_rdata_out, e);
    endtask : rd
    task automatic rreg(input logic [11:0] a, input logic [7:0] e);
        go(3'h1, a, 8'h00);
        rd(e);
    endtask : rreg
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            conclude();
        end
    end
    // ********************
    // Tests
    // ********************
    initial begin
        repeat (16) @(posedge core_clk_in);
        srst_in <= 1'b0;
        hw_rst_n_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        go(3'h1, gcr_pkg::ADDR_MCFG1, 8'h00);
        for (int i = 0; i < 6; i++) rd(i == 1 ? 8'h05 : 8'h00);
        $display("Test defaults done");
        foreach (wv[i]) wreg(12'h009 + 12'(i), wv[i]);
        foreach (wv[i]) rreg(12'h009 + 12'(i), wv[i] & mk[i]);
        chk({6'h00, mclk_src_out}, 8'h02);
        chk({ring_osc_pd_out, xa_enable_out, dpll_en_out, apll_en_out, mclk_range_used_out,
             ext_switch_out, mclk_range_out}, 8'hbb);
        chk({ic_en_out, oc_en_out, 2'h0}, 8'hfc);
        chk({gpio1_pin_out, gpio1_pin_oe_out, gpio0_pin_out, gpio0_pin_oe_out, 4'h0}, 8'hd0);
        $display("Test fields done");
        @(posedge core_clk_in);
        nco_only_in <= 1'b1;
        ext_sw_en_in <= 1'b1;
        gpio0_pin_in <= 1'b1;
        wreg(gcr_pkg::ADDR_MCFG1, 8'h12);
        wreg(gcr_pkg::ADDR_MCFG2, 8'h40);
        chk({mclk_src_out, xa_enable_out, ring_osc_pd_out, mclk_range_used_out,
             ext_switch_out, 2'h0}, 8'h64);
        wreg(gcr_pkg::ADDR_PINCFG, 8'h15);
        chk({gpio1_pin_oe_out, gpio0_pin_oe_out, gpio0_pin_out, 3'h0,
             pin_level_status_out}, 8'h63);
        @(posedge core_clk_in);
        pin0_status_in <= 1'b1;
        pin1_status_in <= 1'b1;
        wreg(gcr_pkg::ADDR_PINCFG, 8'h76);
        chk({gpio1_pin_oe_out, gpio0_pin_oe_out, gpio1_pin_out, gpio0_pin_out,
             4'h0}, 8'h80);
        wreg(gcr_pkg::ADDR_MCFG2, 8'h10);
        go(3'h1, gcr_pkg::ADDR_MCFG2, 8'h00);
        rd(8'h10);
        rd(8'h10);
        $display("Test clock select done");
        @(posedge core_clk_in);
        strap_mclk_in <= 3'h2;
        wreg(gcr_pkg::ADDR_MCFG1, 8'h00);
        wreg(gcr_pkg::ADDR_MCFG1, 8'h80);
        chk({7'h00, channel_reset_out}, 8'h01);
        rreg(gcr_pkg::ADDR_MCFG2, 8'h05);
        wreg(gcr_pkg::ADDR_INPUT_CLOCK_ENABLES, 8'h07);
        rreg(gcr_pkg::ADDR_INPUT_CLOCK_ENABLES, 8'h00);
        wreg(gcr_pkg::ADDR_MCFG1, 8'h00);
        chk({7'h00, channel_reset_out}, 8'h00);
        $display("Test soft reset done");
        wreg(gcr_pkg::ADDR_BANK, 8'h01);
        chk({7'h00, ee_sel_out}, 8'h01);
        rreg(gcr_pkg::ADDR_BANK, 8'h00);
        rreg(12'h005, 8'ha5);
        wreg(12'h007, 8'h3c);
        chk({ee_addr_out[11:8], ee_addr_out[3:0]}, 8'h07);
        chk(ee_wdata_out, 8'h3c);
        wreg(gcr_pkg::ADDR_BANK, 8'h00);
        rreg(12'h020, 8'h00);
        chk({7'h00, ee_sel_out}, 8'h00);
        $display("Test bank select done");
        conclude();
    end
endmodule : gcr_regbank_tb
